/* design/dhrs_consts.svh */
`ifndef DHRS_CONSTS_SVH
`define DHRS_CONSTS_SVH

// Clock rate
`define DHRS_CLK_HZ              25000000
// Times in their own units
`define DHRS_REJECT_US           5
`define DHRS_ACCEPT_US           9
`define DHRS_LOAD_MS             5
`define DHRS_BLANK_MS            120
// Derived cycle counts: least times round up, longest round down
`define DHRS_REJECT_CYC          ((`DHRS_REJECT_US * `DHRS_CLK_HZ + 999999) / 1000000)
`define DHRS_ACCEPT_CYC          ((`DHRS_ACCEPT_US * `DHRS_CLK_HZ + 999999) / 1000000)
// Divide first: the blanking product overflows a 32-bit int
`define DHRS_LOAD_CYC            (`DHRS_LOAD_MS * (`DHRS_CLK_HZ / 1000))
`define DHRS_BLANK_CYC           (`DHRS_BLANK_MS * (`DHRS_CLK_HZ / 1000))
// Settings memory layout
`define DHRS_NV_WORDS            8
`define DHRS_NV_ID0              0
`define DHRS_NV_ID1              1
`define DHRS_NV_ID2              2
`define DHRS_NV_COMMON_VOLTAGE_SETTING             3
// Neutral identification defaults, values arbitrary
`define DHRS_DEF_ID              8'h00
`define DHRS_DEF_COMMON_VOLTAGE_SETTING            8'h20

`endif

/* design/dhrs_pkg.sv */
package dhrs_pkg;
    typedef enum logic [2:0] {
        DHRS_RUN,
        DHRS_HOLD,
        DHRS_BLANK,
        DHRS_LOAD,
        DHRS_DONE
    } dhrs_state_t;
endpackage

/* design/dhrs_pulse_filter.sv */
`timescale 1ns/100ps
`default_nettype none
`include "dhrs_consts.svh"

module dhrs_pulse_filter #(
    parameter int REJECT_CYC = `DHRS_REJECT_CYC,
    parameter int ACCEPT_CYC = `DHRS_ACCEPT_CYC
) (
    input  wire logic clock,
    input  wire logic rst,
    input  wire logic pin_n,
    output logic      reset_hold
);
    logic       sync1;
    logic       sync2;
    logic [9:0] low_cnt;
    logic [9:0] high_cnt;
    wire        low_long  = (low_cnt >= 10'(ACCEPT_CYC));
    wire        high_long = (high_cnt >= 10'(REJECT_CYC));
    wire        low_mid   = (low_cnt >= 10'(REJECT_CYC));

    always_ff @(posedge clock) begin
        sync1 <= rst ? 1'b1 : pin_n;
        sync2 <= rst ? 1'b1 : sync1;
    end

    // Pulses under the reject width never count; between widths, start a reset
    always_ff @(posedge clock) begin
        if (rst) begin
            low_cnt    <= 10'h000;
            high_cnt   <= 10'h000;
            reset_hold <= 1'b0;
        end else begin
            low_cnt  <= sync2 ? 10'h000 : (low_long ? low_cnt : low_cnt + 10'h001);
            high_cnt <= !sync2 ? 10'h000 : (high_long ? high_cnt : high_cnt + 10'h001);
            if (!reset_hold && !sync2 && (low_long || low_mid)) begin
                reset_hold <= 1'b1;
            end else if (reset_hold && high_long) begin
                reset_hold <= 1'b0;
            end
        end
    end

    a_short_reject: assert property (@(posedge clock) disable iff (rst)
        $rose(reset_hold) |-> $past(low_cnt) >= 10'(REJECT_CYC) - 10'h001)
        else $error("reset accepted from a short pulse");
    a_spike_hold: assert property (@(posedge clock) disable iff (rst)
        reset_hold && !high_long && sync2 |=> reset_hold)
        else $error("reset dropped on a short high spike");
endmodule

`default_nettype wire

/* design/dhrs_sequencer.sv */
// Notes on behaviour
// - Low reset pulses shorter than 5us are ignored, longer than 9us reset, and between may reset.
// - Short high spikes during an accepted reset pulse are filtered the same way.
// - Each reset release reloads the identification bytes and voltage setting from storage.
// - The settings load completes within 5ms of the reset pin rising.
// - Reset while awake runs a blanking sequence of at most 120ms; asleep display_blank clears once the settings load completes.
// - After the reset period sleep_default returns to its default; the identification bytes and voltage setting hold stored values.
// - Reset taken while asleep completes within 5 ms.
// - Reset taken while awake completes within 120 ms.
`timescale 1ns/100ps
`default_nettype none
`include "dhrs_consts.svh"

module dhrs_sequencer #(
    parameter int LOAD_CYC  = `DHRS_LOAD_CYC,
    parameter int BLANK_CYC = `DHRS_BLANK_CYC
) (
    input  wire logic       clock,
    input  wire logic       rst,
    input  wire logic       hw_reset_pin_n,
    input  wire logic       sleep_out,
    input  wire logic [7:0] nv_data,
    output logic [2:0]      nv_addr,
    output logic            display_blank,
    output logic            reset_busy,
    output logic            sleep_default,
    output logic [7:0]      id_byte0,
    output logic [7:0]      id_byte1,
    output logic [7:0]      id_byte2,
    output logic [7:0]      common_voltage_setting
);
    dhrs_pkg::dhrs_state_t state;
    dhrs_pkg::dhrs_state_t next_state;
    logic        reset_hold;
    logic        awake_at_start;
    logic [22:0] timer;
    logic [2:0]  load_idx;
    logic        load_done;
    logic [22:0] blank_cycles;

    dhrs_pulse_filter u_filter (
        .clock      (clock),
        .rst        (rst),
        .pin_n      (hw_reset_pin_n),
        .reset_hold (reset_hold)
    );

    // Load runs one word per cycle, far inside the load limit
    wire last_word = (load_idx == 3'(`DHRS_NV_WORDS - 1));
    wire blank_end = (timer >= 23'(BLANK_CYC - 1));
    wire load_due  = (timer >= 23'(LOAD_CYC - 1));

    always_comb begin
        next_state = state;
        unique case (state)
            dhrs_pkg::DHRS_RUN:   if (reset_hold) next_state = dhrs_pkg::DHRS_HOLD;
            dhrs_pkg::DHRS_HOLD:  if (!reset_hold)
                next_state = awake_at_start ? dhrs_pkg::DHRS_BLANK : dhrs_pkg::DHRS_LOAD;
            dhrs_pkg::DHRS_BLANK: if (reset_hold) next_state = dhrs_pkg::DHRS_HOLD;
                else if (load_done && blank_end) next_state = dhrs_pkg::DHRS_DONE;
            dhrs_pkg::DHRS_LOAD:  if (reset_hold) next_state = dhrs_pkg::DHRS_HOLD;
                else if (load_done) next_state = dhrs_pkg::DHRS_DONE;
            dhrs_pkg::DHRS_DONE:  next_state = dhrs_pkg::DHRS_RUN;
        endcase
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            state          <= dhrs_pkg::DHRS_RUN;
            awake_at_start <= 1'b0;
            timer          <= 23'h000000;
            load_idx       <= 3'h0;
            load_done      <= 1'b0;
        end else begin
            state <= next_state;
            if (state == dhrs_pkg::DHRS_RUN && reset_hold) begin
                awake_at_start <= sleep_out;
            end
            timer <= (state == dhrs_pkg::DHRS_HOLD) ? 23'h000000 : timer + 23'h000001;
            if (state == dhrs_pkg::DHRS_HOLD) begin
                load_idx  <= 3'h0;
                load_done <= 1'b0;
            end else if (!load_done && !load_due) begin
                load_idx  <= last_word ? load_idx : load_idx + 3'h1;
                load_done <= last_word;
            end
        end
    end

    assign nv_addr = load_idx;

    // Registers take defaults while held, then stored values on release
    always_ff @(posedge clock) begin
        if (rst || state == dhrs_pkg::DHRS_HOLD) begin
            id_byte0               <= `DHRS_DEF_ID;
            id_byte1               <= `DHRS_DEF_ID;
            id_byte2               <= `DHRS_DEF_ID;
            common_voltage_setting <= `DHRS_DEF_COMMON_VOLTAGE_SETTING;
            sleep_default          <= 1'b1;
        end else if (!load_done && state != dhrs_pkg::DHRS_RUN) begin
            if (load_idx == 3'(`DHRS_NV_ID0)) id_byte0 <= nv_data;
            if (load_idx == 3'(`DHRS_NV_ID1)) id_byte1 <= nv_data;
            if (load_idx == 3'(`DHRS_NV_ID2)) id_byte2 <= nv_data;
            if (load_idx == 3'(`DHRS_NV_COMMON_VOLTAGE_SETTING)) common_voltage_setting <= nv_data;
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            display_blank <= 1'b1;
            reset_busy    <= 1'b1;
        end else begin
            display_blank <= (next_state != dhrs_pkg::DHRS_RUN);
            reset_busy    <= (next_state != dhrs_pkg::DHRS_RUN);
        end
    end

    // Checker only: length of the blanking stay
    always_ff @(posedge clock) begin
        if (rst) begin
            blank_cycles <= 23'h000000;
        end else begin
            blank_cycles <= (state == dhrs_pkg::DHRS_BLANK) ? blank_cycles + 23'h000001
                                                            : 23'h000000;
        end
    end

    a_asleep_bound: assert property (@(posedge clock) disable iff (rst)
        $fell(reset_hold) && !awake_at_start |-> ##[1:12] state == dhrs_pkg::DHRS_DONE)
        else $error("asleep reset did not complete in time");
    a_load_order: assert property (@(posedge clock) disable iff (rst)
        state == dhrs_pkg::DHRS_DONE |-> load_done)
        else $error("completed before settings load");
    a_default_common_voltage_setting: assert property (@(posedge clock) disable iff (rst)
        state == dhrs_pkg::DHRS_HOLD |=> common_voltage_setting == `DHRS_DEF_COMMON_VOLTAGE_SETTING)
        else $error("voltage setting not defaulted");
    a_blank_held: assert property (@(posedge clock) disable iff (rst)
        state == dhrs_pkg::DHRS_BLANK |=> display_blank)
        else $error("display not blank during blanking");
    a_common_voltage_setting_load: assert property (@(posedge clock) disable iff (rst)
        state == dhrs_pkg::DHRS_LOAD && load_idx == 3'(`DHRS_NV_COMMON_VOLTAGE_SETTING) && !load_done
        |=> common_voltage_setting == $past(nv_data))
        else $error("voltage setting not reloaded");
    a_awake_min: assert property (@(posedge clock) disable iff (rst)
        state == dhrs_pkg::DHRS_BLANK && !blank_end |=> state != dhrs_pkg::DHRS_DONE)
        else $error("blanking ended early");
    c_asleep: cover property (@(posedge clock) disable iff (rst)
        state == dhrs_pkg::DHRS_LOAD ##1 state == dhrs_pkg::DHRS_DONE);
    c_awake: cover property (@(posedge clock) disable iff (rst)
        state == dhrs_pkg::DHRS_BLANK ##1 state == dhrs_pkg::DHRS_DONE);
    c_retrig: cover property (@(posedge clock) disable iff (rst)
        state == dhrs_pkg::DHRS_LOAD ##1 state == dhrs_pkg::DHRS_HOLD);
    c_start: cover property (@(posedge clock) disable iff (rst)
        state == dhrs_pkg::DHRS_RUN ##1 state == dhrs_pkg::DHRS_HOLD);
    c_blank_retrig: cover property (@(posedge clock) disable iff (rst)
        state == dhrs_pkg::DHRS_BLANK ##1 state == dhrs_pkg::DHRS_HOLD);

    a_hold_blank: assert property (@(posedge clock) disable iff (rst)
        state == dhrs_pkg::DHRS_HOLD |=> display_blank)
        else $error("display not blank while reset held");

    a_run_idle: assert property (@(posedge clock) disable iff (rst)
        state == dhrs_pkg::DHRS_RUN && !reset_hold |=> !reset_busy)
        else $error("busy while idle");

    a_default_id0: assert property (@(posedge clock) disable iff (rst)
        state == dhrs_pkg::DHRS_HOLD |=> id_byte0 == `DHRS_DEF_ID)
        else $error("first id byte not defaulted");

    a_default_id1: assert property (@(posedge clock) disable iff (rst)
        state == dhrs_pkg::DHRS_HOLD |=> id_byte1 == `DHRS_DEF_ID)
        else $error("second id byte not defaulted");

    a_default_id2: assert property (@(posedge clock) disable iff (rst)
        state == dhrs_pkg::DHRS_HOLD |=> id_byte2 == `DHRS_DEF_ID)
        else $error("third id byte not defaulted");

    a_default_sleep: assert property (@(posedge clock) disable iff (rst)
        state == dhrs_pkg::DHRS_HOLD |=> sleep_default)
        else $error("sleep default not restored");

    a_load_restart: assert property (@(posedge clock) disable iff (rst)
        state == dhrs_pkg::DHRS_HOLD |=> nv_addr == 3'h0)
        else $error("load does not restart at first word");

    a_id0_load: assert property (@(posedge clock) disable iff (rst)
        state != dhrs_pkg::DHRS_HOLD && state != dhrs_pkg::DHRS_RUN && !load_done
        && load_idx == 3'(`DHRS_NV_ID0) |=> id_byte0 == $past(nv_data))
        else $error("first id byte not reloaded");

    a_id1_load: assert property (@(posedge clock) disable iff (rst)
        state != dhrs_pkg::DHRS_HOLD && state != dhrs_pkg::DHRS_RUN && !load_done
        && load_idx == 3'(`DHRS_NV_ID1) |=> id_byte1 == $past(nv_data))
        else $error("second id byte not reloaded");

    a_id2_load: assert property (@(posedge clock) disable iff (rst)
        state != dhrs_pkg::DHRS_HOLD && state != dhrs_pkg::DHRS_RUN && !load_done
        && load_idx == 3'(`DHRS_NV_ID2) |=> id_byte2 == $past(nv_data))
        else $error("third id byte not reloaded");

    a_awake_path: assert property (@(posedge clock) disable iff (rst)
        state == dhrs_pkg::DHRS_HOLD && !reset_hold && awake_at_start
        |=> state == dhrs_pkg::DHRS_BLANK)
        else $error("awake reset skipped blanking");

    a_asleep_path: assert property (@(posedge clock) disable iff (rst)
        state == dhrs_pkg::DHRS_HOLD && !reset_hold && !awake_at_start
        |=> state == dhrs_pkg::DHRS_LOAD)
        else $error("asleep reset did not go to load");

    a_retrig_hold: assert property (@(posedge clock) disable iff (rst)
        (state == dhrs_pkg::DHRS_BLANK || state == dhrs_pkg::DHRS_LOAD
        || state == dhrs_pkg::DHRS_HOLD) && reset_hold |=> state == dhrs_pkg::DHRS_HOLD)
        else $error("new reset not taken");

    a_awake_bound: assert property (@(posedge clock) disable iff (rst)
        blank_cycles <= 23'(BLANK_CYC))
        else $error("blanking ran past its limit");
endmodule

`default_nettype wire

/* testbench/dhrs_host_model.sv */
`timescale 1ns/100ps
`default_nettype none
module dhrs_host_model (
    input  wire logic       clock,
    input  wire logic [2:0] nv_addr,
    output logic            pin_n,
    output logic [7:0]      nv_data
);
    logic [7:0] mem [8];
    // Settings storage answers in the same cycle
    assign nv_data = mem[nv_addr];
    initial pin_n = 1'b1;
    // Host never issues commands here, so no early command can occur
    // Low, optional high spike, low again; a short spike breaks the low on purpose
    task automatic pulse(input int low_a, input int spike, input int low_b);
        @(posedge clock);
        pin_n <= 1'b0;
        repeat (low_a) @(posedge clock);
        if (spike > 0) begin
            pin_n <= 1'b1;
            repeat (spike) @(posedge clock);
            pin_n <= 1'b0;
            repeat (low_b) @(posedge clock);
        end
        pin_n <= 1'b1;
    endtask
endmodule
`default_nettype wire

/* testbench/display_hw_reset_sequencer_tb_top.sv */
`timescale 1ns/100ps
`default_nettype none
module display_hw_reset_sequencer_tb_top;
    localparam int LOAD  = 200;
    localparam int BLANK = 400;
    logic       clock = 1'b0;
    logic       rst = 1'b1;
    logic       sleep_out = 1'b0;
    logic       pin_n;
    logic [7:0] nv_data;
    logic [2:0] nv_addr;
    logic       display_blank;
    logic       reset_busy;
    logic       sleep_default;
    logic [7:0] id_byte0;
    logic [7:0] id_byte1;
    logic [7:0] id_byte2;
    logic [7:0] common_voltage_setting;
    int         n_fail = 0;
    int         tests_run = 0;
    logic       seen;
    always #20 clock = ~clock;
    dhrs_host_model dhrs_host_model_i (.clock(clock), .nv_addr(nv_addr), .pin_n(pin_n),
        .nv_data(nv_data));
    dhrs_sequencer #(.LOAD_CYC(LOAD), .BLANK_CYC(BLANK)) dhrs_sequencer_i (
        .clock(clock), .rst(rst), .hw_reset_pin_n(pin_n), .sleep_out(sleep_out),
        .nv_data(nv_data), .nv_addr(nv_addr), .display_blank(display_blank),
        .reset_busy(reset_busy), .sleep_default(sleep_default), .id_byte0(id_byte0),
        .id_byte1(id_byte1), .id_byte2(id_byte2),
        .common_voltage_setting(common_voltage_setting));
    // Generous bound on completion; the filter adds its release width
    function automatic int busy_limit(input logic awake);
        return 2 + 125 + LOAD + (awake ? BLANK : 0) + 20;
    endfunction
    task automatic chk_bit(input logic got, input logic exp);
        tests_run++;
        if (got !== exp) begin
            n_fail++;
            $display("mismatch at %0t: flag %b expected %b", $time, got, exp);
        end
    endtask
    task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
        tests_run++;
        if (got !== exp) begin
            n_fail++;
            $display("mismatch at %0t: byte %h expected %h", $time, got, exp);
        end
    endtask
    task automatic fill_nv();
        for (int i = 0; i < 8; i++) begin
            dhrs_host_model_i.mem[i] = 8'($urandom);
        end
    endtask
    // Bounded wait; counts cycles up to the limit so a hung sequence cannot stall the run
    task automatic wait_idle(input int limit);
        int n;
        n = 0;
        while (reset_busy !== 1'b0 && n < limit) begin
            @(posedge clock);
            #1;
            n++;
        end
        chk_bit(n < limit, 1'b1);
    endtask
    task automatic chk_loaded();
        chk_byte(id_byte0, dhrs_host_model_i.mem[0]);
        chk_byte(id_byte1, dhrs_host_model_i.mem[1]);
        chk_byte(id_byte2, dhrs_host_model_i.mem[2]);
        chk_byte(common_voltage_setting, dhrs_host_model_i.mem[3]);
        chk_bit(sleep_default, 1'b1);
        chk_bit(display_blank, 1'b0);
    endtask
    task automatic print_verdict();
        if (n_fail == 0 && tests_run > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    initial begin
        #(40 * 20000);
        n_fail++;
        print_verdict();
    end
    initial begin
        void'($urandom(32'h6aaad07d));
        fill_nv();
        repeat (5) @(posedge clock);
        rst <= 1'b0;
        repeat (5) @(posedge clock);
        #1;
        chk_bit(reset_busy, 1'b0);
        // Glitch of 60 cycles, well under the reject width
        seen = 1'b0;
        fork
            dhrs_host_model_i.pulse(60, 0, 0);
            repeat (300) begin
                @(posedge clock);
                #1;
                seen = seen | (reset_busy === 1'b1);
            end
        join
        chk_bit(seen, 1'b0);
        // Asleep, pulse just over the full reset width
        dhrs_host_model_i.pulse(230 + ($urandom % 80), 0, 0);
        repeat (3) @(posedge clock);
        #1;
        chk_bit(reset_busy, 1'b1);
        chk_bit(display_blank, 1'b1);
        wait_idle(busy_limit(1'b0));
        chk_loaded();
        // Awake, new storage contents, a short high spike inside the pulse
        fill_nv();
        @(posedge clock);
        sleep_out <= 1'b1;
        fork
            dhrs_host_model_i.pulse(200, 30, 200);
            begin
                repeat (240) @(posedge clock);
                #1;
                chk_bit(reset_busy, 1'b1);
            end
        join
        repeat (300) @(posedge clock);
        #1;
        chk_bit(display_blank, 1'b1);
        @(posedge clock);
        sleep_out <= 1'b0;
        wait_idle(busy_limit(1'b1));
        chk_loaded();
        print_verdict();
    end
endmodule
`default_nettype wire
